// >>> pkg/eia_map.svh
// Register indices, field positions and reset values of the event interrupt aggregator
`ifndef EIA_MAP_SVH
`define EIA_MAP_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define EIA_CHIP_N 32
`define EIA_LINK_GRP_N 7
`define EIA_LANE_N 8
`define EIA_LINK_N 56
`define EIA_PEND_N 3
`define EIA_IDX_W 11

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define EIA_CHIP_ARM_IDX 11'h01F
`define EIA_PATTERN_FAIL_ARM_IDX 11'h020
`define EIA_PAIR_A_EVENT_ARM_IDX 11'h021
`define EIA_PAIR_B_EVENT_ARM_IDX 11'h022
`define EIA_CHIP_STAT_IDX 11'h023
`define EIA_PATTERN_FAIL_STATUS_IDX 11'h024
`define EIA_PAIR_A_EVENT_STATUS_IDX 11'h025
`define EIA_PAIR_B_EVENT_STATUS_IDX 11'h026
`define EIA_CHIP_REG_N 4
`define EIA_LINK_CLR_IDX 11'h46D
`define EIA_LINK_EVENT_ARM_STATUS_IDX 11'h47A
`define EIA_LINK_SINGLE_EVENT_CTRL_IDX 11'h47B
`define EIA_IRQ_MASK_IDX 11'h480
`define EIA_IRQ_PEND_IDX 11'h481

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define EIA_SINGLE_ARM_BIT 3
`define EIA_SINGLE_SRC_BIT 4
`define EIA_SINGLE_ARM_RST 1'h1
`define EIA_MASK_RST 3'h7
`define EIA_BLANK_DONE_BIT 5
`define EIA_GUARD_TRIP_BIT 7

`endif

// >>> pkg/eia_pkg.sv
// Types shared by the event interrupt aggregator
`default_nettype none
`include "eia_map.svh"

package eia_pkg;

  typedef struct packed {
    logic [`EIA_CHIP_N-1:0] chip_s1;
    logic [`EIA_CHIP_N-1:0] chip_s2;
    logic [`EIA_CHIP_N-1:0] chip_prev;
    logic [`EIA_CHIP_N-1:0] chip_arm;
    logic [`EIA_CHIP_N-1:0] chip_src;
    logic [`EIA_LINK_N-1:0] link_s1;
    logic [`EIA_LINK_N-1:0] link_s2;
    logic [`EIA_LINK_N-1:0] link_prev;
    logic [`EIA_LINK_GRP_N-1:0] link_arm;
    logic [`EIA_LINK_N-1:0] link_src;
    logic single_s1;
    logic single_s2;
    logic single_prev;
    logic single_arm;
    logic single_src;
    logic [`EIA_PEND_N-1:0] mask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq_oe;
    logic irq_pin;
  } eia_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`EIA_IDX_W-1:0] idx;
    logic aligned;
    logic [31:0] pwdata;
  } eia_apb_req_t;

endpackage

`default_nettype wire

// >>> hdl/eia_event_interrupt_aggregator.sv
// Event interrupt aggregator: sticky armed event sources, APB registers, open-drain request
//
// Our own choice: the APB register port.
`default_nettype none
`include "eia_map.svh"

// Function
// - Request pin is open-drain, active low
// - Disarmed event holds latched source at zero
// - Armed event latches on every rising edge
// - Any latched source whose mask bit is set pulls request pin low
// - Clear write or reset zeroes latched source
// - Chip status: latched if armed, else live
// - Link status: latched if armed, else zero
// - Four chip arm registers, four clear/status
// - Link arm register; separate link clear registers
// - Single link event: arm bit3, status bit4
// - Pair A blanking done: bit 5
// - Pair B blanking done: bit 5
// - Four pattern-check failures: bits 3 to 0
// - Up to 89 events across all blocks
// - Pair A power guard trip: bit 7
module eia_event_interrupt_aggregator (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Event levels: chip bytes follow the chip arm registers, link by group and lane
  input wire logic [`EIA_CHIP_N-1:0] chip_event_i,
  input wire logic [`EIA_LINK_N-1:0] link_event_i,
  input wire logic link_single_event_i,
  // Open-drain request pin
  output logic irq_n_o,
  output logic irq_n_oe
);

  eia_pkg::eia_state_t st_q;
  eia_pkg::eia_state_t st_d;
  eia_pkg::eia_apb_req_t req;
  logic [`EIA_CHIP_N-1:0] chip_rise;
  logic [`EIA_LINK_N-1:0] link_rise;
  logic single_rise;
  logic [`EIA_LINK_N-1:0] link_arm_lanes;
  logic take;
  logic wr_en;
  logic [`EIA_PEND_N-1:0] pend_d;
  logic [`EIA_PEND_N-1:0] pend_q;

  // --------------------------------------------------------------------------
  // Address decoding
  // --------------------------------------------------------------------------
  function automatic logic eia_mapped(input logic [`EIA_IDX_W-1:0] idx);
    eia_mapped = (idx >= `EIA_CHIP_ARM_IDX && idx <= `EIA_PAIR_B_EVENT_STATUS_IDX) ||
                 (idx >= `EIA_LINK_CLR_IDX &&
                  idx < `EIA_LINK_CLR_IDX + `EIA_IDX_W'(`EIA_LINK_GRP_N)) ||
                 idx == `EIA_LINK_EVENT_ARM_STATUS_IDX ||
                 idx == `EIA_LINK_SINGLE_EVENT_CTRL_IDX ||
                 idx == `EIA_IRQ_MASK_IDX || idx == `EIA_IRQ_PEND_IDX;
  endfunction

  function automatic logic [7:0] eia_read(input logic [`EIA_IDX_W-1:0] idx,
                                          input eia_pkg::eia_state_t s,
                                          input logic [`EIA_PEND_N-1:0] pend);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < `EIA_CHIP_REG_N; i++) begin
      // Arm bytes; pattern, blanking and guard-trip bits sit in bytes 1 to 3
      if (idx == `EIA_CHIP_ARM_IDX + `EIA_IDX_W'(i)) begin
        v = s.chip_arm[i*8 +: 8];
      end
      // Unarmed chip bits show the live level so software can poll them
      if (idx == `EIA_CHIP_STAT_IDX + `EIA_IDX_W'(i)) begin
        v = (s.chip_arm[i*8 +: 8] & s.chip_src[i*8 +: 8]) |
            (~s.chip_arm[i*8 +: 8] & s.chip_s2[i*8 +: 8]);
      end
    end
    for (int g = 0; g < `EIA_LINK_GRP_N; g++) begin
      if (idx == `EIA_LINK_CLR_IDX + `EIA_IDX_W'(g) && s.link_arm[g]) begin
        v = s.link_src[g*8 +: 8];
      end
      if (idx == `EIA_LINK_EVENT_ARM_STATUS_IDX) begin
        v[g] = s.link_arm[g] & (|s.link_src[g*8 +: 8]);
      end
    end
    if (idx == `EIA_LINK_SINGLE_EVENT_CTRL_IDX) begin
      v[`EIA_SINGLE_ARM_BIT] = s.single_arm;
      v[`EIA_SINGLE_SRC_BIT] = s.single_arm & s.single_src;
    end
    if (idx == `EIA_IRQ_MASK_IDX) begin
      v[`EIA_PEND_N-1:0] = s.mask;
    end
    if (idx == `EIA_IRQ_PEND_IDX) begin
      v[`EIA_PEND_N-1:0] = pend;
    end
    eia_read = v;
  endfunction

  assign req.psel = psel;
  assign req.penable = penable;
  assign req.pwrite = pwrite;
  assign req.idx = paddr[`EIA_IDX_W+1:2];
  assign req.aligned = (paddr[1:0] == 2'h0) && (paddr[31:`EIA_IDX_W+2] == '0);
  assign req.pwdata = pwdata;

  // Writes act only at the edge where the master sees pready
  assign take = req.psel && req.penable && !st_q.pready;
  assign wr_en = req.psel && req.penable && st_q.pready && req.pwrite &&
                 req.aligned && eia_mapped(req.idx);

  // --------------------------------------------------------------------------
  // Edge detection
  // --------------------------------------------------------------------------
  assign chip_rise = st_q.chip_s2 & ~st_q.chip_prev;
  assign link_rise = st_q.link_s2 & ~st_q.link_prev;
  assign single_rise = st_q.single_s2 & ~st_q.single_prev;
  assign pend_q = {st_q.single_src, |st_q.link_src, |st_q.chip_src};

  // Group arm spread over its lanes; the source logic and the checks share it
  for (genvar g = 0; g < `EIA_LINK_GRP_N; g++) begin : g_lane_arm
    assign link_arm_lanes[g*`EIA_LANE_N +: `EIA_LANE_N] = {`EIA_LANE_N{st_q.link_arm[g]}};
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic [`EIA_CHIP_N-1:0] chip_clr;
    logic [`EIA_LINK_N-1:0] link_clr;
    logic single_clr;
    chip_clr = '0;
    link_clr = '0;
    single_clr = 1'h0;
    st_d = st_q;
    // Levels may come from other clock domains; two flops before any use
    st_d.chip_s1 = chip_event_i;
    st_d.chip_s2 = st_q.chip_s1;
    st_d.chip_prev = st_q.chip_s2;
    st_d.link_s1 = link_event_i;
    st_d.link_s2 = st_q.link_s1;
    st_d.link_prev = st_q.link_s2;
    st_d.single_s1 = link_single_event_i;
    st_d.single_s2 = st_q.single_s1;
    st_d.single_prev = st_q.single_s2;

    if (wr_en) begin
      for (int i = 0; i < `EIA_CHIP_REG_N; i++) begin
        if (req.idx == `EIA_CHIP_ARM_IDX + `EIA_IDX_W'(i)) begin
          st_d.chip_arm[i*8 +: 8] = req.pwdata[7:0];
        end
        if (req.idx == `EIA_CHIP_STAT_IDX + `EIA_IDX_W'(i)) begin
          chip_clr[i*8 +: 8] = req.pwdata[7:0];
        end
      end
      for (int g = 0; g < `EIA_LINK_GRP_N; g++) begin
        if (req.idx == `EIA_LINK_CLR_IDX + `EIA_IDX_W'(g)) begin
          link_clr[g*8 +: 8] = req.pwdata[7:0];
        end
      end
      if (req.idx == `EIA_LINK_EVENT_ARM_STATUS_IDX) begin
        st_d.link_arm = req.pwdata[`EIA_LINK_GRP_N-1:0];
      end
      if (req.idx == `EIA_LINK_SINGLE_EVENT_CTRL_IDX) begin
        st_d.single_arm = req.pwdata[`EIA_SINGLE_ARM_BIT];
        single_clr = req.pwdata[`EIA_SINGLE_SRC_BIT];
      end
      if (req.idx == `EIA_IRQ_MASK_IDX) begin
        st_d.mask = req.pwdata[`EIA_PEND_N-1:0];
      end
    end

    // A rising edge in the clearing cycle wins, so no event is lost
    for (int b = 0; b < `EIA_CHIP_N; b++) begin
      st_d.chip_src[b] = st_q.chip_arm[b] &
                         (chip_rise[b] | (st_q.chip_src[b] & ~chip_clr[b]));
    end
    for (int b = 0; b < `EIA_LINK_N; b++) begin
      st_d.link_src[b] = link_arm_lanes[b] &
                         (link_rise[b] | (st_q.link_src[b] & ~link_clr[b]));
    end
    st_d.single_src = st_q.single_arm &
                      (single_rise | (st_q.single_src & ~single_clr));

    // 32 chip + 56 link-lane + 1 single sources cover the 89 possible events
    pend_d = {st_d.single_src, |st_d.link_src, |st_d.chip_src};
    st_d.irq_oe = |(pend_d & st_d.mask);
    st_d.irq_pin = 1'h0;

    // APB answer one cycle into the access phase
    st_d.pready = take;
    st_d.pslverr = take && !(req.aligned && eia_mapped(req.idx));
    st_d.prdata = st_q.prdata;
    if (take) begin
      st_d.prdata = (!req.pwrite && req.aligned) ? {24'h000000, eia_read(req.idx, st_q, pend_q)}
                                                  : 32'h00000000;
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= '0;
      st_q.single_arm <= `EIA_SINGLE_ARM_RST;
      st_q.mask <= `EIA_MASK_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign prdata = st_q.prdata;
  assign irq_n_o = st_q.irq_pin;
  assign irq_n_oe = st_q.irq_oe;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_pin_never_high;
    irq_n_oe |-> !irq_n_o;
  endproperty
  a_pin_never_high: assert property (p_pin_never_high) else $error("request pin driven high");

  property p_disarmed_zero;
    (st_q.chip_src & ~$past(st_q.chip_arm)) == '0;
  endproperty
  a_disarmed_zero: assert property (p_disarmed_zero) else $error("disarmed source set");

  property p_rise_latches;
    (|(chip_rise & st_q.chip_arm)) |=>
      ((st_q.chip_src & $past(chip_rise & st_q.chip_arm)) == $past(chip_rise & st_q.chip_arm));
  endproperty
  a_rise_latches: assert property (p_rise_latches) else $error("armed edge not latched");

  property p_pin_follows;
    ((st_q.single_src && st_q.mask[2]) || (|st_q.chip_src && st_q.mask[0])) |-> irq_n_oe;
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("request pin not pulled");

  property p_clear;
    wr_en && req.idx == `EIA_CHIP_STAT_IDX && req.pwdata[0] && !chip_rise[0]
      |=> !st_q.chip_src[0] ##1 (irq_n_oe == |(pend_q & st_q.mask));
  endproperty
  a_clear: assert property (p_clear) else $error("clear write ignored");

  property p_live_read;
    take && !req.pwrite && req.aligned && req.idx == `EIA_CHIP_STAT_IDX && !st_q.chip_arm[0]
      |=> pready && prdata[0] == $past(st_q.chip_s2[0]);
  endproperty
  a_live_read: assert property (p_live_read) else $error("unarmed chip status not live");

  property p_link_zero;
    take && !req.pwrite && req.aligned && req.idx == `EIA_LINK_EVENT_ARM_STATUS_IDX &&
      !st_q.link_arm[0] |=> !prdata[0];
  endproperty
  a_link_zero: assert property (p_link_zero) else $error("unarmed link status nonzero");

  property p_single_arm_hold;
    !(wr_en && req.idx == `EIA_LINK_SINGLE_EVENT_CTRL_IDX) |=> $stable(st_q.single_arm);
  endproperty
  a_single_arm_hold: assert property (p_single_arm_hold) else $error("single arm changed");

  property p_answer;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer) else $error("APB answer not in one cycle");

  property p_link_disarmed_zero;
    (st_q.link_src & ~$past(link_arm_lanes)) == '0;
  endproperty
  a_link_disarmed_zero: assert property (p_link_disarmed_zero)
    else $error("disarmed lane set");

  property p_single_disarmed_zero;
    st_q.single_src |-> $past(st_q.single_arm);
  endproperty
  a_single_disarmed_zero: assert property (p_single_disarmed_zero)
    else $error("disarmed single source set");

  property p_link_rise_latches;
    (|(link_rise & link_arm_lanes)) |=>
      ((st_q.link_src & $past(link_rise & link_arm_lanes)) == $past(link_rise & link_arm_lanes));
  endproperty
  a_link_rise_latches: assert property (p_link_rise_latches)
    else $error("armed lane edge not latched");

  property p_single_rise_latches;
    single_rise && st_q.single_arm |=> st_q.single_src;
  endproperty
  a_single_rise_latches: assert property (p_single_rise_latches)
    else $error("armed single edge not latched");

  property p_pin_exact;
    irq_n_oe == ((|st_q.chip_src && st_q.mask[0]) || (|st_q.link_src && st_q.mask[1]) ||
                 (st_q.single_src && st_q.mask[2]));
  endproperty
  a_pin_exact: assert property (p_pin_exact)
    else $error("request pin not matching sources");

  property p_link_clear;
    wr_en && req.idx == `EIA_LINK_CLR_IDX + 11'h002 && req.pwdata[3] && !link_rise[19]
      |=> !st_q.link_src[19];
  endproperty
  a_link_clear: assert property (p_link_clear)
    else $error("lane clear write ignored");

  property p_single_clear;
    wr_en && req.idx == `EIA_LINK_SINGLE_EVENT_CTRL_IDX && req.pwdata[`EIA_SINGLE_SRC_BIT] &&
      !single_rise |=> !st_q.single_src;
  endproperty
  a_single_clear: assert property (p_single_clear)
    else $error("single clear write ignored");

  property p_blank_a_read;
    take && !req.pwrite && req.aligned && req.idx == `EIA_PAIR_A_EVENT_STATUS_IDX &&
      st_q.chip_arm[2*8+`EIA_BLANK_DONE_BIT]
      |=> prdata[`EIA_BLANK_DONE_BIT] == $past(st_q.chip_src[2*8+`EIA_BLANK_DONE_BIT]);
  endproperty
  a_blank_a_read: assert property (p_blank_a_read)
    else $error("armed blanking status not latched value");

  property p_blank_b_read;
    take && !req.pwrite && req.aligned && req.idx == `EIA_PAIR_B_EVENT_STATUS_IDX &&
      st_q.chip_arm[3*8+`EIA_BLANK_DONE_BIT]
      |=> prdata[`EIA_BLANK_DONE_BIT] == $past(st_q.chip_src[3*8+`EIA_BLANK_DONE_BIT]);
  endproperty
  a_blank_b_read: assert property (p_blank_b_read)
    else $error("pair B blanking status wrong");

  property p_guard_read;
    take && !req.pwrite && req.aligned && req.idx == `EIA_PAIR_A_EVENT_STATUS_IDX &&
      !st_q.chip_arm[2*8+`EIA_GUARD_TRIP_BIT]
      |=> prdata[`EIA_GUARD_TRIP_BIT] == $past(st_q.chip_s2[2*8+`EIA_GUARD_TRIP_BIT]);
  endproperty
  a_guard_read: assert property (p_guard_read)
    else $error("unarmed guard trip status not live");

  property p_link_lane_zero;
    take && !req.pwrite && req.aligned && req.idx == `EIA_LINK_CLR_IDX + 11'h001 &&
      !st_q.link_arm[1] |=> prdata[7:0] == 8'h00;
  endproperty
  a_link_lane_zero: assert property (p_link_lane_zero)
    else $error("unarmed lane status nonzero");

  property p_arm_write;
    wr_en && req.idx == `EIA_CHIP_ARM_IDX |=> st_q.chip_arm[7:0] == $past(req.pwdata[7:0]);
  endproperty
  a_arm_write: assert property (p_arm_write)
    else $error("chip arm write lost");

  property p_slverr;
    take && !(req.aligned && eia_mapped(req.idx)) |=> pslverr && prdata == 32'h00000000;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("unmapped access not refused");

  property p_link_arm_write;
    wr_en && req.idx == `EIA_LINK_EVENT_ARM_STATUS_IDX
      |=> st_q.link_arm == $past(req.pwdata[`EIA_LINK_GRP_N-1:0]);
  endproperty
  a_link_arm_write: assert property (p_link_arm_write)
    else $error("link arm write lost");

  property p_reset_values;
    $fell(reset) |-> st_q.single_arm && st_q.mask == `EIA_MASK_RST &&
                     st_q.chip_arm == '0 && st_q.link_arm == '0;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("arm values wrong after reset");

  property p_pattern_clear;
    wr_en && req.idx == `EIA_PATTERN_FAIL_STATUS_IDX && req.pwdata[0] && !chip_rise[8]
      |=> !st_q.chip_src[8];
  endproperty
  a_pattern_clear: assert property (p_pattern_clear)
    else $error("pattern fail clear ignored");

  property p_sync_delay;
    st_q.chip_s2 == $past(chip_event_i, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("chip event sync delay wrong");

  c_latch: cover property (|(chip_rise & st_q.chip_arm) ##1 irq_n_oe);
  c_clear: cover property (wr_en && req.idx == `EIA_LINK_SINGLE_EVENT_CTRL_IDX ##1 !irq_n_oe);
  c_slverr: cover property (pready && pslverr);
  c_link: cover property (|st_q.link_src);

endmodule

`default_nettype wire

// >>> testbench/eia_irq_line_model.sv
// Wired-OR request line with pull-up and one other open-drain requester
`default_nettype none
module eia_irq_line_model (
  // Device pin
  input wire logic dev_o,
  input wire logic dev_oe,
  // Other requester sharing the line
  input wire logic other_oe,
  // Resolved line seen by the host
  output logic line_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up wins only while nobody drives
  assign line_n = ((dev_oe && !dev_o) || other_oe) ? 1'h0 : 1'h1;
endmodule
`default_nettype wire

// >>> testbench/event_interrupt_aggregator_tb.sv
// Self-checking bench of the event interrupt aggregator
`default_nettype none
module event_interrupt_aggregator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, irq_n_o, irq_n_oe;
  logic single_ev, other_oe, line_n, er;
  logic [31:0] paddr, pwdata, prdata, chip_ev, rd;
  logic [55:0] link_ev;
  int num_errors, num_checks;
  // write, index, write data, expected read byte, expected error
  localparam logic [28:0] ROWS [15] = '{
    {1'h0, 11'h47B, 8'h00, 8'h08, 1'h0},
    {1'h0, 11'h480, 8'h00, 8'h07, 1'h0},
    {1'h0, 11'h021, 8'h00, 8'h00, 1'h0},
    {1'h1, 11'h01F, 8'hA5, 8'h00, 1'h0},
    {1'h0, 11'h01F, 8'h00, 8'hA5, 1'h0},
    {1'h1, 11'h01F, 8'h00, 8'h00, 1'h0},
    {1'h1, 11'h023, 8'h01, 8'h00, 1'h0},
    {1'h0, 11'h023, 8'h00, 8'h00, 1'h0},
    {1'h1, 11'h020, 8'h0F, 8'h00, 1'h0},
    {1'h0, 11'h020, 8'h00, 8'h0F, 1'h0},
    {1'h1, 11'h021, 8'hA0, 8'h00, 1'h0},
    {1'h0, 11'h021, 8'h00, 8'hA0, 1'h0},
    {1'h1, 11'h022, 8'h20, 8'h00, 1'h0},
    {1'h0, 11'h022, 8'h00, 8'h20, 1'h0},
    {1'h0, 11'h100, 8'h00, 8'h00, 1'h1}
  };

  eia_event_interrupt_aggregator DUT (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .chip_event_i(chip_ev), .link_event_i(link_ev), .link_single_event_i(single_ev),
    .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));

  eia_irq_line_model line (.dev_o(irq_n_o), .dev_oe(irq_n_oe), .other_oe(other_oe),
    .line_n(line_n));

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Host side of every transfer, the service sequence included
  task bus(input logic w, input logic [10:0] idx, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {19'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!pready && n < 50);
    if (n >= 50) num_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task wr(input logic [10:0] idx, input logic [7:0] d);
    bus(1'h1, idx, d);
  endtask

  task rdchk(input logic [10:0] idx, input logic [7:0] exp);
    bus(1'h0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask

  // Synchroniser, edge compare and pin register settle well inside this
  task settle;
    repeat (6) @(posedge ref_clk);
  endtask

  task line_is(input logic exp_n);
    @(negedge ref_clk);
    chk({31'h0, line_n}, {31'h0, exp_n});
    @(posedge ref_clk);
  endtask

  task test_done;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------------------
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    test_done;
  end

  initial begin
    {reset, psel, penable, pwrite, single_ev, other_oe} = 6'h20;
    {paddr, pwdata, chip_ev, link_ev} = '0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'h0;
    foreach (ROWS[i]) begin
      bus(ROWS[i][28], ROWS[i][27:17], ROWS[i][16:9]);
      chk(rd, {24'h0, ROWS[i][8:1]});
      chk({31'h0, er}, {31'h0, ROWS[i][0]});
    end
    @(posedge ref_clk);
    chip_ev[21] <= 1'h1;
    settle;
    line_is(1'h0);
    chk({31'h0, irq_n_o}, 32'h0);
    chip_ev[21] <= 1'h0;
    settle;
    rdchk(11'h025, 8'h20);
    wr(11'h021, 8'h80);
    rdchk(11'h025, 8'h00);
    wr(11'h025, 8'h20);
    wr(11'h021, 8'hA0);
    settle;
    rdchk(11'h025, 8'h00);
    line_is(1'h1);
    other_oe <= 1'h1;
    line_is(1'h0);
    other_oe <= 1'h0;
    // Rearm with the level still high must not latch again
    chip_ev[23] <= 1'h1;
    settle;
    rdchk(11'h025, 8'h80);
    wr(11'h021, 8'h20);
    rdchk(11'h025, 8'h80);
    wr(11'h021, 8'hA0);
    settle;
    rdchk(11'h025, 8'h00);
    line_is(1'h1);
    chip_ev[31:23] <= 9'h140;
    settle;
    rdchk(11'h026, 8'hA0);
    wr(11'h026, 8'h20);
    rdchk(11'h026, 8'h80);
    chip_ev[31:8] <= 24'h00000F;
    settle;
    rdchk(11'h024, 8'h0F);
    wr(11'h024, 8'h05);
    rdchk(11'h024, 8'h0A);
    chip_ev[11:8] <= 4'h0;
    wr(11'h024, 8'h0A);
    rdchk(11'h024, 8'h00);
    // Group 2 armed, group 1 left disarmed
    wr(11'h47A, 8'h04);
    link_ev[19:9] <= 11'h401;
    settle;
    rdchk(11'h46F, 8'h08);
    rdchk(11'h46E, 8'h00);
    rdchk(11'h47A, 8'h04);
    line_is(1'h0);
    link_ev <= '0;
    wr(11'h46F, 8'h08);
    settle;
    rdchk(11'h46F, 8'h00);
    line_is(1'h1);
    // Single link event behind the mask
    wr(11'h480, 8'h03);
    single_ev <= 1'h1;
    settle;
    rdchk(11'h47B, 8'h18);
    line_is(1'h1);
    wr(11'h480, 8'h07);
    settle;
    line_is(1'h0);
    single_ev <= 1'h0;
    wr(11'h47B, 8'h18);
    settle;
    rdchk(11'h47B, 8'h08);
    line_is(1'h1);
    // Reset in mid-run with a source set
    chip_ev[21] <= 1'h1;
    settle;
    line_is(1'h0);
    @(posedge ref_clk);
    reset <= 1'h1;
    chip_ev[21] <= 1'h0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'h0;
    settle;
    rdchk(11'h025, 8'h00);
    rdchk(11'h021, 8'h00);
    rdchk(11'h47B, 8'h08);
    line_is(1'h1);
    test_done;
  end
endmodule
`default_nettype wire
